/* core/rtu_cfg.svh */
// Offsets, field positions, reset values and codes of the rotate unit
`ifndef RTU_CFG_SVH
`define RTU_CFG_SVH

`define RTU_OFS_INSTR   5'h00
`define RTU_OFS_STATUS  5'h04
`define RTU_OFS_WREG    5'h08
`define RTU_OFS_BANK    5'h0C
`define RTU_OFS_CFG     5'h10
`define RTU_OFS_INDEX   5'h14
`define RTU_OFS_MADDR   5'h18
`define RTU_OFS_MDATA   5'h1C

`define RTU_ST_C        0
`define RTU_ST_Z        1
`define RTU_ST_N        2
`define RTU_ST_ILL      4
`define RTU_ST_LOST     5
`define RTU_ST_BUSY     8
`define RTU_CFG_EXT     0

`define RTU_INSTR_A     8
`define RTU_INSTR_D     9
`define RTU_OPC_HI      15
`define RTU_OPC_LO      10
`define RTU_OPC_RLN     6'h11
`define RTU_OPC_RRC     6'h0C

`define RTU_IDX_LIMIT   8'h5F
`define RTU_ACC_SPLIT   8'h60
`define RTU_ACC_LO_BANK 4'h0
`define RTU_ACC_HI_BANK 4'hF

`define RTU_RST_BYTE    8'h00
`define RTU_RST_BANK    4'h0
`define RTU_RST_ADDR    12'h000
`define RTU_RST_INSTR   16'h0000
`endif

/* core/rtu_if.sv */
// Link between the sequencer and the rotate datapath
`timescale 1ns/1ps
interface rtu_if;
    logic       rrc;
    logic [7:0] operand;
    logic       cin;
    logic [7:0] result;
    logic       cout;
    modport ctl (output rrc, output operand, output cin, input result, input cout);
    modport alu (input rrc, input operand, input cin, output result, output cout);
endinterface

/* core/rtu_pkg.sv */
// Types shared by the rotate unit modules
package rtu_pkg;
    typedef enum logic [2:0] {
        RTU_IDLE,
        RTU_DECODE,
        RTU_READ,
        RTU_PROC,
        RTU_WRITE
    } rtu_state_t;
endpackage

/* core/rtu_rot.sv */
// Rotate datapath: left without carry, or right through carry
`timescale 1ns/1ps
module rtu_rot (
    rtu_if.alu rot
);
    // Right rotate threads the carry through bit 7 and bit 0
    always_comb begin
        if (rot.rrc) begin
            rot.result = {rot.cin, rot.operand[7:1]}; // RQ5
            rot.cout   = rot.operand[0];              // RQ5
        end else begin
            rot.result = {rot.operand[6:0], rot.operand[7]}; // RQ1
            rot.cout   = rot.cin;                            // RQ1
        end
    end
endmodule

/* core/rtu_top.sv */
// Rotate instruction unit with its data memory behind an AHB-Lite slave
// Operation
// RQ1 - Left rotate: bit 7 wraps to bit 0
// RQ2 - Destination bit 0 to W, 1 back
// RQ3 - Access bit 0 access bank, 1 bank register
// RQ4 - Extended set: low offsets use indexed addressing
// RQ5 - Right rotate through carry flag
// RQ6 - One instruction: decode, read, process, write phases
//
// Our own choices: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
`include "rtu_cfg.svh"
module rtu_top #(
    parameter int MEM_DEPTH = 4096
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp
);
    import rtu_pkg::*;

    rtu_state_t  st_r,     st_nxt;
    logic        wp_r,     wp_nxt;       // Write data phase pending
    logic [4:0]  wa_r,     wa_nxt;
    logic [31:0] rd_r,     rd_nxt;
    logic [15:0] instr_r,  instr_nxt;
    logic [7:0]  w_r,      w_nxt;
    logic [3:0]  bank_r,   bank_nxt;
    logic        ext_r,    ext_nxt;
    logic [11:0] idx_r,    idx_nxt;
    logic [11:0] maddr_r,  maddr_nxt;
    logic        c_r,      c_nxt;
    logic        z_r,      z_nxt;
    logic        n_r,      n_nxt;
    logic        ill_r,    ill_nxt;
    logic        lost_r,   lost_nxt;
    logic [11:0] addr_r,   addr_nxt;
    logic [7:0]  opnd_r,   opnd_nxt;
    logic [7:0]  res_r,    res_nxt;
    logic        cout_r,   cout_nxt;
    logic        mem_we;
    logic [11:0] mem_wa;
    logic [7:0]  mem_wd;
    logic [7:0]  mem [MEM_DEPTH];
    logic        busy;
    logic        acc;
    logic [7:0]  f_fld;
    logic        a_fld;
    logic        d_fld;
    logic        rrc_op;

    rtu_if rot ();
    rtu_rot u_rot (.rot(rot));

    assign busy      = (st_r != RTU_IDLE);
    assign acc       = hsel && htrans[1] && hready;
    assign f_fld     = instr_r[7:0];
    assign a_fld     = instr_r[`RTU_INSTR_A];
    assign d_fld     = instr_r[`RTU_INSTR_D];
    assign rrc_op    = (instr_r[`RTU_OPC_HI:`RTU_OPC_LO] == `RTU_OPC_RRC);
    assign rot.rrc   = rrc_op;
    assign rot.operand = opnd_r;
    assign rot.cin   = c_r;
    assign hrdata    = rd_r;
    assign hreadyout = 1'b1;                 // Zero wait states, every access
    assign hresp     = 1'b0;

    // Bus slave, register file and instruction sequencer next state
    always_comb begin
        st_nxt = st_r;    wp_nxt = 1'b0;    wa_nxt = wa_r;    rd_nxt = rd_r;
        instr_nxt = instr_r;  w_nxt = w_r;  bank_nxt = bank_r;  ext_nxt = ext_r;
        idx_nxt = idx_r;  maddr_nxt = maddr_r;  c_nxt = c_r;  z_nxt = z_r;
        n_nxt = n_r;  ill_nxt = ill_r;  lost_nxt = lost_r;  addr_nxt = addr_r;
        opnd_nxt = opnd_r;  res_nxt = res_r;  cout_nxt = cout_r;
        mem_we = 1'b0;    mem_wa = maddr_r; mem_wd = hwdata[7:0];
        // Data phase of a write; settings other than MADDR and the ILL/LOST clears stay frozen while an instruction runs
        if (wp_r) begin
            unique case (wa_r)
                `RTU_OFS_INSTR: begin
                    if (busy) begin
                        lost_nxt = 1'b1;
                    end else if (hwdata[`RTU_OPC_HI:`RTU_OPC_LO] == `RTU_OPC_RLN ||
                                 hwdata[`RTU_OPC_HI:`RTU_OPC_LO] == `RTU_OPC_RRC) begin
                        instr_nxt = hwdata[15:0];
                        st_nxt    = RTU_DECODE;               // RQ6
                    end else begin
                        ill_nxt = 1'b1;
                    end
                end
                `RTU_OFS_STATUS: begin
                    if (hwdata[`RTU_ST_ILL])  ill_nxt  = 1'b0;
                    if (hwdata[`RTU_ST_LOST]) lost_nxt = 1'b0;
                    if (!busy) begin
                        c_nxt = hwdata[`RTU_ST_C];
                        z_nxt = hwdata[`RTU_ST_Z];
                        n_nxt = hwdata[`RTU_ST_N];
                    end
                end
                `RTU_OFS_WREG:  if (!busy) w_nxt = hwdata[7:0];
                `RTU_OFS_BANK:  if (!busy) bank_nxt = hwdata[3:0];
                `RTU_OFS_CFG:   if (!busy) ext_nxt = hwdata[`RTU_CFG_EXT];
                `RTU_OFS_INDEX: if (!busy) idx_nxt = hwdata[11:0];
                `RTU_OFS_MADDR: maddr_nxt = hwdata[11:0];
                `RTU_OFS_MDATA: mem_we = !busy;  // Memory port belongs to the sequencer
                default: ;
            endcase
        end
        // Four phases of one instruction cycle
        unique case (st_r)
            RTU_IDLE: ;
            RTU_DECODE: begin
                if (a_fld) begin
                    addr_nxt = {bank_r, f_fld};                                 // RQ3
                end else if (ext_r && f_fld <= `RTU_IDX_LIMIT) begin
                    addr_nxt = idx_r + {4'h0, f_fld};                           // RQ4
                end else if (f_fld < `RTU_ACC_SPLIT) begin
                    addr_nxt = {`RTU_ACC_LO_BANK, f_fld};                       // RQ3
                end else begin
                    addr_nxt = {`RTU_ACC_HI_BANK, f_fld};                       // RQ3
                end
                st_nxt = RTU_READ;                                              // RQ6
            end
            RTU_READ: begin
                opnd_nxt = mem[addr_r];
                st_nxt   = RTU_PROC;                                            // RQ6
            end
            RTU_PROC: begin
                res_nxt  = rot.result;                                          // RQ1
                cout_nxt = rot.cout;                                            // RQ5
                st_nxt   = RTU_WRITE;                                           // RQ6
            end
            RTU_WRITE: begin
                if (d_fld) begin
                    mem_we = 1'b1;                                              // RQ2
                    mem_wa = addr_r;
                    mem_wd = res_r;
                end else begin
                    w_nxt = res_r;                                              // RQ2
                end
                if (rrc_op) c_nxt = cout_r;                                     // RQ5
                z_nxt  = (res_r == 8'h00);
                n_nxt  = res_r[7];
                st_nxt = RTU_IDLE;                                              // RQ6
            end
        endcase
        // Address phase: latch write target, load read data from next values
        if (acc) begin
            wp_nxt = hwrite;
            wa_nxt = {haddr[4:2], 2'b00};
            if (!hwrite) begin
                unique case ({haddr[4:2], 2'b00})
                    `RTU_OFS_INSTR:  rd_nxt = {16'h0000, instr_nxt};
                    `RTU_OFS_STATUS: rd_nxt = {23'h000000, st_nxt != RTU_IDLE, 2'b00,
                                               lost_nxt, ill_nxt, 1'b0, n_nxt, z_nxt, c_nxt};
                    `RTU_OFS_WREG:   rd_nxt = {24'h000000, w_nxt};
                    `RTU_OFS_BANK:   rd_nxt = {28'h0000000, bank_nxt};
                    `RTU_OFS_CFG:    rd_nxt = {31'h00000000, ext_nxt};
                    `RTU_OFS_INDEX:  rd_nxt = {20'h00000, idx_nxt};
                    `RTU_OFS_MADDR:  rd_nxt = {20'h00000, maddr_nxt};
                    `RTU_OFS_MDATA:  rd_nxt = {24'h000000, mem[maddr_nxt]};
                    default:         rd_nxt = 32'h00000000;
                endcase
            end
        end
        // Unmapped upper addresses read as zero and ignore writes
        if (acc && haddr[31:5] != 27'h0000000) begin
            wp_nxt = 1'b0;
            rd_nxt = 32'h00000000;
        end
    end

    // State registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r <= RTU_IDLE;   wp_r <= 1'b0;   wa_r <= 5'h00;   rd_r <= 32'h00000000;
            instr_r <= `RTU_RST_INSTR;  w_r <= `RTU_RST_BYTE;  bank_r <= `RTU_RST_BANK;
            ext_r <= 1'b0;  idx_r <= `RTU_RST_ADDR;  maddr_r <= `RTU_RST_ADDR;
            c_r <= 1'b0;  z_r <= 1'b0;  n_r <= 1'b0;  ill_r <= 1'b0;  lost_r <= 1'b0;
            addr_r <= `RTU_RST_ADDR;  opnd_r <= `RTU_RST_BYTE;  res_r <= `RTU_RST_BYTE;
            cout_r <= 1'b0;
        end else begin
            st_r <= st_nxt;   wp_r <= wp_nxt;   wa_r <= wa_nxt;   rd_r <= rd_nxt;
            instr_r <= instr_nxt;  w_r <= w_nxt;  bank_r <= bank_nxt;  ext_r <= ext_nxt;
            idx_r <= idx_nxt;  maddr_r <= maddr_nxt;  c_r <= c_nxt;  z_r <= z_nxt;
            n_r <= n_nxt;  ill_r <= ill_nxt;  lost_r <= lost_nxt;  addr_r <= addr_nxt;
            opnd_r <= opnd_nxt;  res_r <= res_nxt;  cout_r <= cout_nxt;
        end
    end

    // Data memory has no reset; contents are software's business
    always_ff @(posedge hclk) begin
        if (mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
    end

    // Phase order of one instruction
    sequence s_phases;
        st_r == RTU_DECODE ##1 st_r == RTU_READ ##1 st_r == RTU_PROC
            ##1 st_r == RTU_WRITE ##1 st_r == RTU_IDLE;
    endsequence

    property p_phases; // RQ6
        @(posedge hclk) disable iff (!hresetn) $rose(busy) |-> s_phases;
    endproperty
    a_phases: assert property (p_phases) else $error("instruction phases out of order");

    property p_rln; // RQ1
        @(posedge hclk) disable iff (!hresetn)
            (st_r == RTU_PROC && !rrc_op) |=>
                res_r == {$past(opnd_r[6:0]), $past(opnd_r[7])} && cout_r == $past(c_r);
    endproperty
    a_rln: assert property (p_rln) else $error("left rotate result wrong");

    property p_rrc; // RQ5
        @(posedge hclk) disable iff (!hresetn)
            (st_r == RTU_PROC && rrc_op) |=>
                (res_r == {$past(c_r), $past(opnd_r[7:1])} && cout_r == $past(opnd_r[0])
                 && st_r == RTU_WRITE) ##1 c_r == $past(cout_r);
    endproperty
    a_rrc: assert property (p_rrc) else $error("right rotate through carry wrong");

    property p_dest_w; // RQ2
        @(posedge hclk) disable iff (!hresetn)
            (st_r == RTU_WRITE && !d_fld) |-> !mem_we ##1 w_r == $past(res_r);
    endproperty
    a_dest_w: assert property (p_dest_w) else $error("result did not reach W");

    property p_dest_f; // RQ2
        @(posedge hclk) disable iff (!hresetn)
            (st_r == RTU_WRITE && d_fld) |->
                mem_we && mem_wa == addr_r && mem_wd == res_r ##1 w_r == $past(w_r);
    endproperty
    a_dest_f: assert property (p_dest_f) else $error("result not written back");

    property p_bank; // RQ3
        @(posedge hclk) disable iff (!hresetn)
            (st_r == RTU_READ) |->
                (a_fld ? addr_r == {bank_r, f_fld} :
                 ((ext_r && f_fld <= `RTU_IDX_LIMIT) ||
                  (addr_r[7:0] == f_fld &&
                   addr_r[11:8] == (f_fld < `RTU_ACC_SPLIT ? `RTU_ACC_LO_BANK
                                                          : `RTU_ACC_HI_BANK))));
    endproperty
    a_bank: assert property (p_bank) else $error("operand bank selection wrong");

    property p_indexed; // RQ4
        @(posedge hclk) disable iff (!hresetn)
            (st_r == RTU_READ && !a_fld && ext_r && f_fld <= `RTU_IDX_LIMIT) |->
                addr_r == 12'(idx_r + {4'h0, f_fld});
    endproperty
    a_indexed: assert property (p_indexed) else $error("indexed operand address wrong");
endmodule

/* verif/rotate_instruction_unit_bench.sv */
// Self-checking bench for the rotate unit over its AHB-Lite slave
`timescale 1ns/1ps
`include "rtu_cfg.svh"
module rotate_instruction_unit_bench;
    import rtu_pkg::*;
    typedef struct {string nm; logic [31:0] v; logic [31:0] m;} rtu_note_t;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    wire         hready;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    rtu_note_t   notes[$];
    rtu_note_t   nt;
    logic        rd_pend = 1'b0;
    logic [31:0] seed = 32'd41247;
    int          fail_count = 0;
    int          compares = 0;
    int          cycles = 0;

    // One slave, so its ready is the bus ready
    assign hready = hreadyout;
    always #12.5 hclk = ~hclk;

    rtu_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Operand address from the access, extension and bank settings
    function automatic logic [11:0] eaddr(logic a, logic ext, logic [7:0] f,
                                          logic [3:0] bk, logic [11:0] ix);
        if (a) return {bk, f};
        if (ext && f <= 8'h5F) return ix + {4'h0, f};
        return (f < 8'h60) ? {4'h0, f} : {4'hF, f};
    endfunction

    task automatic print_verdict();
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Master holds each phase until ready is seen high at an edge
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hsel <= 1'b0;
        if (w) hwdata <= d;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        q = hrdata;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask

    task automatic rd(input string nm, input logic [31:0] a, input logic [31:0] e,
                      input logic [31:0] m);
        logic [31:0] q;
        notes.push_back('{nm, e, m});
        xfer(1'b0, a, 32'h0, q);
    endtask

    // Wait for the sequencer to go idle, bounded
    task automatic poll();
        logic [31:0] q;
        int n;
        n = 0;
        do begin
            notes.push_back('{"poll", 32'h0, 32'h0});
            xfer(1'b0, `RTU_OFS_STATUS, 32'h0, q);
            n++;
        end while (q[`RTU_ST_BUSY] !== 1'b0 && n < 20);
        if (n >= 20) begin
            $display("unexpected busy expected 0 seen 1");
            fail_count++;
        end
    endtask

    // Read data is taken at the edge that ends the data phase
    always @(posedge hclk) begin
        if (rd_pend && notes.size() > 0) begin
            nt = notes.pop_front();
            if (nt.m != 32'h0) begin
                compares++;
                if ((hrdata & nt.m) !== (nt.v & nt.m)) begin
                    $display("unexpected %s expected %h seen %h", nt.nm, nt.v & nt.m,
                             hrdata & nt.m);
                    fail_count++;
                end
            end
        end
        rd_pend <= hresetn && hsel && htrans[1] && !hwrite && hready;
        if (hresetn && hresp !== 1'b0) begin
            $display("unexpected hresp expected 0 seen %b", hresp);
            fail_count++;
        end
    end

    // Hang guard, well above the length of the sequence
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            print_verdict();
        end
    end

    initial begin : main
        static logic [7:0] tf [8] = '{8'hC3, 8'h20, 8'h10, 8'hA0, 8'h5F, 8'h60, 8'h00, 8'h5F};
        static logic       ta [8] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
        static logic       tx [8] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
        logic [31:0] r;
        logic [31:0] st;
        logic [11:0] ad;
        logic [7:0]  op;
        logic [7:0]  res;
        logic        co;
        logic        rrc;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd("status", `RTU_OFS_STATUS, 32'h0, 32'hFFFFFFFF);
        rd("wreg", `RTU_OFS_WREG, 32'h0, 32'hFFFFFFFF);
        wr(32'h20, 32'hFFFFFFFF);
        rd("unmapped", 32'h20, 32'h0, 32'hFFFFFFFF);
        $display("test reset done");
        // Both rotates, both destinations, every addressing path
        for (int i = 0; i < 8; i++) begin
            r = rnd();
            op = r[7:0];
            rrc = i[0];
            wr(`RTU_OFS_BANK, {28'h0, r[11:8]});
            wr(`RTU_OFS_INDEX, {20'h0, r[23:12]});
            wr(`RTU_OFS_CFG, {31'h0, tx[i]});
            wr(`RTU_OFS_WREG, 32'h5A);
            wr(`RTU_OFS_STATUS, {31'h0, r[24]});
            ad = eaddr(ta[i], tx[i], tf[i], r[11:8], r[23:12]);
            wr(`RTU_OFS_MADDR, {20'h0, ad});
            wr(`RTU_OFS_MDATA, {24'h0, op});
            wr(`RTU_OFS_INSTR, {16'h0, rrc ? `RTU_OPC_RRC : `RTU_OPC_RLN, i[1], ta[i], tf[i]});
            poll();
            res = rrc ? {r[24], op[7:1]} : {op[6:0], op[7]};
            co = rrc ? op[0] : r[24];
            st = {29'h0, res[7], res == 8'h0, co};
            rd("status", `RTU_OFS_STATUS, st, 32'h107);
            rd("wreg", `RTU_OFS_WREG, i[1] ? 32'h5A : {24'h0, res}, 32'hFF);
            wr(`RTU_OFS_MADDR, {20'h0, ad});
            rd("mdata", `RTU_OFS_MDATA, i[1] ? {24'h0, res} : {24'h0, op}, 32'hFF);
            $display("test rotate case %0d done", i);
        end
        // Known operand at bank 0 offset 0, so the datapath checks never see X
        wr(`RTU_OFS_BANK, 32'h0);
        wr(`RTU_OFS_MADDR, 32'h0);
        wr(`RTU_OFS_MDATA, 32'h81);
        // Busy for the four phases, idle at the fifth edge
        wr(`RTU_OFS_INSTR, {16'h0, `RTU_OPC_RLN, 2'b11, 8'h00});
        repeat (2) @(posedge hclk);
        rd("busy", `RTU_OFS_STATUS, 32'h100, 32'h100);
        rd("busy", `RTU_OFS_STATUS, 32'h0, 32'h100);
        // Back-to-back instructions: the second is lost
        wr(`RTU_OFS_INSTR, {16'h0, `RTU_OPC_RRC, 2'b11, 8'h00});
        wr(`RTU_OFS_INSTR, {16'h0, `RTU_OPC_RRC, 2'b11, 8'h00});
        poll();
        rd("lost", `RTU_OFS_STATUS, 32'h20, 32'h30);
        wr(`RTU_OFS_STATUS, 32'h20);
        wr(`RTU_OFS_INSTR, 32'hFC00);
        rd("ill", `RTU_OFS_STATUS, 32'h10, 32'h130);
        $display("test busy and flags done");
        print_verdict();
    end
endmodule
